// ### core/rmb_pkg.sv
// Purpose: Shared constants and carrier types for the reset mode loader.
// Assumes: Core clock of 40 MHz; serial clock at 16 times the bit rate from the far side.
// Notes:   Offsets, vectors and serial framing counts live here; the FIFO depth is a loader parameter.
`default_nettype none
package rmb_pkg;
    // Mode values held in the four mode bits.
    localparam logic [3:0] MODE_EXPANDED = 4'h0;
    localparam logic [3:0] MODE_BYTE_MEM = 4'h1;
    localparam logic [3:0] MODE_SERIAL   = 4'h2;
    localparam logic [3:0] MODE_RESERVED = 4'h3;
    localparam logic [3:0] MODE_HOST_ISA = 4'h4;
    localparam logic [3:0] MODE_NO_LOAD  = 4'h8;
    // Program space addresses.
    localparam logic [23:0] LOADER_ENTRY   = 24'hff0000;
    localparam logic [23:0] EXPANDED_START = 24'hc00000;
    localparam logic [17:0] EXPANDED_PINS  = 18'h00000;
    localparam logic [23:0] BYTE_MEM_START = 24'hd00000;
    // External bus access settings.
    localparam logic [4:0]  BOOT_WAIT_STATES = 5'h1f;
    localparam logic [1:0]  ACCESS_STATIC    = 2'h0;
    localparam logic [3:0]  ATTR_NONE        = 4'h0;
    localparam logic [3:0]  ATTR_STROBE_ONE  = 4'h2;
    // Serial framing: 16 samples per bit, 8 data bits, 1 stop bit.
    localparam logic [3:0]  SER_OVERSAMPLE_LAST = 4'hf;
    localparam logic [3:0]  SER_MID_SAMPLE      = 4'h7;
    localparam logic [3:0]  SER_DATA_BITS       = 4'h8;
    localparam logic [1:0]  BYTES_PER_WORD      = 2'h3;
    // A program word with its internal destination address.
    typedef struct packed {
        logic [23:0] addr;
        logic [23:0] data;
    } rmb_word_s;
endpackage
`default_nettype wire

// ### core/rmb_fifo.sv
// Purpose: Small flip-flop FIFO between word assembly and program memory.
// Assumes: Single clock; valid/ready on both sides.
// Notes:   Full and empty are exact; source stalls when full.
`default_nettype none
module rmb_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             resetn,
    // Filling side.
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side.
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];   // Entry storage.
    logic [AW-1:0]    wrPtr;           // Next slot to write.
    logic [AW-1:0]    rdPtr;           // Next slot to read.
    logic [AW:0]      count;           // Entries held.
    wire              doWrite = inValid && inReady;
    wire              doRead  = outValid && outReady;

    // Status derived from the fill count.
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = store[rdPtr];

    // Storage written only by the filling side.
    always_ff @(posedge clk)
    begin
        if (doWrite)
            store[wrPtr] <= inData;
    end

    // Pointers and count move with each handshake.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (doWrite)
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            if (doRead)
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end
endmodule
`default_nettype wire

// ### core/rmb_loader.sv
// Purpose: Captures the operating mode at reset exit and runs the loader.
// Assumes: Serial receive/transmit run on serClk, 16 times the baud rate.
// Notes:   Program words pass through an eight-entry FIFO to memory.
`default_nettype none
module rmb_loader #(
    parameter int FIFO_DEPTH = 8
) (
    // Core clock and reset.
    input  wire logic        clk,
    input  wire logic        resetn,
    // Mode pins and software mode write.
    input  wire logic        modePinA,
    input  wire logic        modePinB,
    input  wire logic        modePinC,
    input  wire logic        modePinD,
    input  wire logic        modeWrite,
    input  wire logic [3:0]  modeWriteData,
    input  wire logic        loaderJump,
    output logic [3:0]       operatingModeReg,
    // External boot memory bus.
    output logic             extRead,
    output logic [23:0]      extAddr,
    output logic [17:0]      extPinAddr,
    output logic [1:0]       extAccessType,
    output logic [4:0]       extWaitStates,
    output logic [3:0]       extAttrStrobe,
    input  wire logic        extReadDone,
    input  wire logic [7:0]  extReadData,
    // Serial port on the far side's clock.
    input  wire logic        serClk,
    input  wire logic        serRxd,
    output logic             serTxd,
    // Host port words and host flag zero.
    input  wire logic        hostValid,
    input  wire logic [23:0] hostData,
    output logic             hostReady,
    input  wire logic        hostFlagZero,
    // Program memory write port.
    output logic             progWrite,
    output logic [23:0]      progAddr,
    output logic [23:0]      progData,
    input  wire logic        progReady,
    // Execution start.
    output logic             runStart,
    output logic [23:0]      runAddr,
    output logic             loaderBusy
);
    typedef enum {ST_CAPTURE, ST_DISPATCH, ST_MEM_REQ, ST_MEM_WAIT, ST_SERIAL,
                  ST_HOST, ST_DRAIN, ST_RUN} rmb_state_e;
    rmb_state_e state;                      // Loader sequence state.
    logic [1:0]  phase;                     // 0 count, 1 start, 2 words.
    logic [1:0]  byteIdx;                   // Byte within current triple.
    logic [23:0] shiftWord;                 // Triple being assembled.
    logic [23:0] wordCount;                 // Words left to load.
    logic [23:0] startAddr;                 // Load and run address.
    logic [23:0] loadAddr;                  // Next program address.
    logic [23:0] memPtr;                    // Next byte-wide location.
    logic        fifoValid;                 // Word offered to the FIFO.
    rmb_pkg::rmb_word_s fifoIn;             // Word and destination.
    rmb_pkg::rmb_word_s fifoOut;            // Word leaving the FIFO.
    logic        fifoReady;                 // FIFO has room.
    logic        fifoOutValid;              // FIFO holds a word.
    logic        hostFlagSync1, hostFlagSync2, hostFlagSync3;

    // Byte stream from memory or serial receiver.
    logic        byteValid;
    logic [7:0]  byteData;
    logic        rxToggleS1, rxToggleS2, rxToggleS3;
    logic [7:0]  rxByteCore;                // Serial byte sampled in core domain.
    logic        rxTaken;                   // A fresh byte sits in rxByteCore.
    wire         rxNew     = rxToggleS2 ^ rxToggleS3;
    wire         hostAbort = hostFlagSync2 && hostFlagSync3;
    wire [23:0]  nextWord  = {byteData, shiftWord[23:8]};
    wire         tripleEnd = byteValid && (byteIdx == 2'h2);
    wire [3:0]   pinMode   = {modePinD, modePinC, modePinB, modePinA};

    // Byte source selection follows the active routine.
    assign byteValid = (state == ST_MEM_WAIT && extReadDone) || (state == ST_SERIAL && rxTaken);
    assign byteData  = (state == ST_SERIAL) ? rxByteCore : extReadData;

    // Host flag passes three flip-flops; a set flag counts when 2nd and 3rd both read high.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hostFlagSync1 <= 1'b0;
            hostFlagSync2 <= 1'b0;
            hostFlagSync3 <= 1'b0;
        end
        else
        begin
            hostFlagSync1 <= hostFlagZero;
            hostFlagSync2 <= hostFlagSync1;
            hostFlagSync3 <= hostFlagSync2;
        end
    end

    // Serial receiver on the link clock, 16 samples per bit.
    logic [2:0]  rxPinS;                    // Receive pin synchroniser.
    logic        rxActive;
    logic [3:0]  rxTick;
    logic [3:0]  rxBitNo;
    logic [7:0]  rxShift;
    logic [7:0]  rxByte;                    // Held until next byte completes.
    logic        rxToggle;                  // Flips once per received byte.
    wire         rxLine = rxPinS[2];
    always_ff @(posedge serClk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxPinS   <= 3'h7;
            rxActive <= 1'b0;
            rxTick   <= '0;
            rxBitNo  <= '0;
            rxShift  <= '0;
            rxByte   <= '0;
            rxToggle <= 1'b0;
        end
        else
        begin
            rxPinS <= {rxPinS[1:0], serRxd};
            if (!rxActive)
            begin
                // Start bit seen when the agreeing stages both read low.
                rxTick   <= '0;
                rxBitNo  <= '0;
                rxActive <= !rxPinS[1] && !rxPinS[2];
            end
            else
            begin
                rxTick <= rxTick + 4'h1;
                if (rxTick == rmb_pkg::SER_MID_SAMPLE)
                begin
                    if (rxBitNo == '0 && rxLine)
                        rxActive <= 1'b0;          // False start, back to idle.
                    else if (rxBitNo == rmb_pkg::SER_DATA_BITS + 4'h1)
                    begin
                        // Stop bit sampled: byte complete, no parity bit.
                        rxActive <= 1'b0;
                        rxByte   <= rxShift;
                        rxToggle <= ~rxToggle;
                    end
                    else if (rxBitNo != '0)
                        rxShift <= {rxLine, rxShift[7:1]};
                end
                if (rxTick == rmb_pkg::SER_OVERSAMPLE_LAST)
                    rxBitNo <= rxBitNo + 4'h1;
            end
        end
    end

    // Serial transmitter echoes every completed byte on the link clock.
    logic [9:0]  txShift;
    logic [3:0]  txTick;
    logic [3:0]  txBits;
    logic        txEcho;                    // Last toggle value echoed.
    always_ff @(posedge serClk or negedge resetn)
    begin
        if (!resetn)
        begin
            txShift <= 10'h3ff;
            txTick  <= '0;
            txBits  <= '0;
            txEcho  <= 1'b0;
            serTxd  <= 1'b1;
        end
        else if (txBits == '0 && txEcho != rxToggle)
        begin
            // Frame: start, eight data bits LSB first, one stop.
            txEcho  <= rxToggle;
            txShift <= {1'b1, rxByte, 1'b0};
            txBits  <= 4'ha;
            txTick  <= '0;
        end
        else if (txBits != '0)
        begin
            serTxd <= txShift[0];
            txTick <= txTick + 4'h1;
            if (txTick == rmb_pkg::SER_OVERSAMPLE_LAST)
            begin
                txShift <= {1'b1, txShift[9:1]};
                txBits  <= txBits - 4'h1;
            end
        end
        else
            serTxd <= 1'b1;
    end

    // Byte-done toggle crosses by three flops; the byte is offered the cycle after its copy is taken.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxToggleS1 <= 1'b0;
            rxToggleS2 <= 1'b0;
            rxToggleS3 <= 1'b0;
            rxByteCore <= '0;
            rxTaken    <= 1'b0;
        end
        else
        begin
            rxToggleS1 <= rxToggle;
            rxToggleS2 <= rxToggleS1;
            rxToggleS3 <= rxToggleS2;
            rxTaken    <= rxNew;
            if (rxNew)
                rxByteCore <= rxByte;
        end
    end

    // Loader sequence: capture, dispatch, load, drain, run.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state            <= ST_CAPTURE;
            operatingModeReg <= '0;
            phase            <= '0;
            byteIdx          <= '0;
            shiftWord        <= '0;
            wordCount        <= '0;
            startAddr        <= '0;
            loadAddr         <= '0;
            memPtr           <= '0;
            fifoValid        <= 1'b0;
            fifoIn           <= '0;
            extRead          <= 1'b0;
            extAddr          <= '0;
            extPinAddr       <= '0;
            extAccessType    <= rmb_pkg::ACCESS_STATIC;
            extWaitStates    <= rmb_pkg::BOOT_WAIT_STATES;
            extAttrStrobe    <= rmb_pkg::ATTR_NONE;
            hostReady        <= 1'b0;
            runStart         <= 1'b0;
            runAddr          <= '0;
            loaderBusy       <= 1'b1;
        end
        else
        begin
            runStart <= 1'b0;
            if (fifoValid && fifoReady)
                fifoValid <= 1'b0;
            if (modeWrite)
                operatingModeReg <= modeWriteData;
            case (state)
                ST_CAPTURE:
                begin
                    operatingModeReg <= pinMode;
                    state            <= ST_DISPATCH;
                end
                ST_DISPATCH:
                begin
                    phase      <= '0;
                    byteIdx    <= '0;
                    loaderBusy <= 1'b1;
                    memPtr     <= rmb_pkg::BYTE_MEM_START;
                    case (operatingModeReg)
                        rmb_pkg::MODE_EXPANDED:
                        begin
                            // External fetch at the reset vector.
                            extAccessType <= rmb_pkg::ACCESS_STATIC;
                            extWaitStates <= rmb_pkg::BOOT_WAIT_STATES;
                            extAttrStrobe <= rmb_pkg::ATTR_NONE;
                            extPinAddr    <= rmb_pkg::EXPANDED_PINS;
                            runAddr       <= rmb_pkg::EXPANDED_START;
                            state         <= ST_RUN;
                        end
                        rmb_pkg::MODE_BYTE_MEM:
                        begin
                            extAttrStrobe <= rmb_pkg::ATTR_STROBE_ONE;
                            extWaitStates <= rmb_pkg::BOOT_WAIT_STATES;
                            state         <= ST_MEM_REQ;
                        end
                        rmb_pkg::MODE_SERIAL:   state <= ST_SERIAL;
                        rmb_pkg::MODE_HOST_ISA: state <= ST_HOST;
                        default:
                        begin
                            // Reserved and unsupported modes stay idle.
                            loaderBusy <= 1'b0;
                            state      <= ST_RUN;
                            runAddr    <= rmb_pkg::LOADER_ENTRY;
                        end
                    endcase
                end
                ST_MEM_REQ:
                begin
                    extRead    <= 1'b1;
                    extAddr    <= memPtr;
                    extPinAddr <= memPtr[17:0];
                    state      <= ST_MEM_WAIT;
                end
                ST_MEM_WAIT, ST_SERIAL:
                begin
                    if (byteValid && !(tripleEnd && phase == 2'h2 && fifoValid))
                    begin
                        extRead   <= 1'b0;
                        memPtr    <= memPtr + 24'h1;
                        shiftWord <= nextWord;
                        byteIdx   <= tripleEnd ? 2'h0 : byteIdx + 2'h1;
                        if (tripleEnd)
                        begin
                            // Store a completed triple by phase.
                            if (phase == 2'h0)
                                wordCount <= nextWord;
                            else if (phase == 2'h1)
                            begin
                                startAddr <= nextWord;
                                loadAddr  <= nextWord;
                            end
                            else
                            begin
                                fifoValid   <= 1'b1;
                                fifoIn.addr <= loadAddr;
                                fifoIn.data <= nextWord;
                                loadAddr    <= loadAddr + 24'h1;
                                wordCount   <= wordCount - 24'h1;
                            end
                            if (phase != 2'h2)
                                phase <= phase + 2'h1;
                        end
                        if (tripleEnd && ((phase == 2'h0 && nextWord == '0) ||
                            (phase == 2'h2 && wordCount == 24'h1)))
                            state <= ST_DRAIN;
                        else if (state == ST_MEM_WAIT)
                            state <= ST_MEM_REQ;
                    end
                    else if (byteValid && state == ST_MEM_WAIT)
                        extRead <= 1'b1;
                end
                ST_HOST:
                begin
                    // Whole 24-bit words from the host.
                    hostReady <= !fifoValid && !hostAbort;
                    if (hostAbort)
                        state <= ST_DRAIN;
                    else if (hostValid && hostReady)
                    begin
                        hostReady <= 1'b0;
                        if (phase == 2'h0)
                        begin
                            wordCount <= hostData;
                            phase     <= 2'h1;
                        end
                        else if (phase == 2'h1)
                        begin
                            startAddr <= hostData;
                            loadAddr  <= hostData;
                            phase     <= 2'h2;
                            if (wordCount == '0)
                                state <= ST_DRAIN;
                        end
                        else
                        begin
                            fifoValid   <= 1'b1;
                            fifoIn.addr <= loadAddr;
                            fifoIn.data <= hostData;
                            loadAddr    <= loadAddr + 24'h1;
                            wordCount   <= wordCount - 24'h1;
                            if (wordCount == 24'h1)
                                state <= ST_DRAIN;
                        end
                    end
                end
                ST_DRAIN:
                begin
                    // Run only once every word has reached memory.
                    hostReady <= 1'b0;
                    if (!fifoValid && !fifoOutValid)
                    begin
                        runAddr  <= startAddr;
                        runStart <= 1'b1;
                        state    <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (loaderBusy && runAddr == rmb_pkg::EXPANDED_START)
                        runStart <= 1'b1;
                    loaderBusy <= 1'b0;
                    // Jump to the loader entry reruns by mode bits.
                    if (loaderJump && operatingModeReg != rmb_pkg::MODE_EXPANDED
                        && operatingModeReg != rmb_pkg::MODE_NO_LOAD)
                        state <= ST_DISPATCH;
                end
                default: state <= ST_CAPTURE;
            endcase
        end
    end

    // Word FIFO between assembly and program memory.
    rmb_fifo #(
        .WIDTH (48),
        .DEPTH (FIFO_DEPTH)
    ) wordFifo (
        .clk      (clk),
        .resetn   (resetn),
        .inValid  (fifoValid),
        .inReady  (fifoReady),
        .inData   (fifoIn),
        .outValid (fifoOutValid),
        .outReady (progReady),
        .outData  (fifoOut)
    );

    // Program memory port registered from the FIFO head.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            progWrite <= 1'b0;
            progAddr  <= '0;
            progData  <= '0;
        end
        else
        begin
            progWrite <= fifoOutValid && progReady;
            progAddr  <= fifoOut.addr;
            progData  <= fifoOut.data;
        end
    end
endmodule
`default_nettype wire

// ### test/rmb_loader_assertions.sv
// Purpose: Port-level timing checks on the reset mode loader.
// Assumes: One core clock domain, asynchronous active-low reset.
// Notes:   Bound to every loader instance at the foot of this file.
`default_nettype none
module rmb_loader_assertions (
    // Clock, reset and mode straps.
    input wire logic        clk, resetn, modePinA, modePinB, modePinC, modePinD,
    // Boot memory bus.
    input wire logic        extRead, extReadDone,
    input wire logic [23:0] extAddr,
    input wire logic [17:0] extPinAddr,
    input wire logic [1:0]  extAccessType,
    input wire logic [4:0]  extWaitStates,
    input wire logic [3:0]  extAttrStrobe, operatingModeReg,
    // Host, program memory and run.
    input wire logic        hostValid, hostReady, progWrite, progReady, runStart,
    input wire logic [23:0] runAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // One byte handed over by the boot memory.
    sequence byteDone;
        extRead && extReadDone;
    endsequence
    mode_capture_a:
        assert property (disable iff (1'b0) $rose(resetn) |=> operatingModeReg ==
            $past({modePinD, modePinC, modePinB, modePinA})) else $error("mode not captured");
    wait_states_a:
        assert property (extRead |-> extWaitStates == 5'h1f) else $error("wait states");
    strobe_one_a:
        assert property (extRead && operatingModeReg == 4'h1 |-> extAttrStrobe == 4'h2
            && extAccessType == 2'h0) else $error("boot memory select");
    expanded_run_a:
        assert property (runStart && operatingModeReg == 4'h0 |-> runAddr == 24'hc00000
            && extAttrStrobe == 4'h0 && extPinAddr == 18'h0) else $error("expanded start");
    read_hold_a:
        assert property (extRead && !extReadDone |=> extRead && $stable(extAddr))
            else $error("read request dropped");
    byte_gap_a:
        assert property (byteDone |=> !extRead) else $error("read not released");
    prog_cause_a:
        assert property (progWrite |-> $past(progReady)) else $error("write while stalled");
    run_pulse_a:
        assert property (runStart |=> !runStart) else $error("run start too long");
    reserved_idle_a:
        assert property (operatingModeReg == 4'h3 |-> !extRead && !progWrite && !runStart)
            else $error("reserved mode active");
    host_take_a:
        assert property (hostValid && hostReady |=> !hostReady) else $error("host ready held");
endmodule
bind rmb_loader rmb_loader_assertions u_rmb_loader_assertions (.*);
`default_nettype wire

// ### test/rmb_boot_mem.sv
// Purpose: Byte-wide boot memory answering the loader's reads.
// Assumes: One answer per request, one cycle after it is seen.
// Notes:   Data lines toggle whenever no answer is due.
`default_nettype none
module rmb_boot_mem (
    input  wire logic        clk,
    input  wire logic        extRead,
    input  wire logic [23:0] extAddr,
    output logic             extReadDone,
    output logic [7:0]       extReadData
);
    timeunit 1ns;
    timeprecision 1ps;
    // Count 2, start 0x000010, then two words, each low byte first.
    logic [7:0] img [16] = '{8'h02, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h56, 8'h34,
        8'h12, 8'hef, 8'hcd, 8'hab, 8'h00, 8'h00, 8'h00, 8'h00};
    initial extReadDone = 1'b0;
    initial extReadData = 8'h00;
    // Answer a standing request once, from the addressed location.
    always @(posedge clk)
    begin
        extReadDone <= #2 extRead && !extReadDone;
        extReadData <= #2 (extRead && !extReadDone) ? img[extAddr[3:0]] : ~extReadData;
    end
endmodule
`default_nettype wire

// ### test/rmb_loader_tb_top.sv
// Purpose: Boots the loader in modes 0 to 4 and checks what it loads.
// Assumes: Core clock 25 ns, serial clock 125 ns from the far side.
// Notes:   Expected values come from the memory image and sent bytes.
`default_nettype none
module rmb_loader_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, serClk = 1'b0, resetn = 1'b0, serRxd = 1'b1, progReady = 1'b1, serTxd;
    logic modeWrite = 1'b0, loaderJump = 1'b0, hostValid = 1'b0, hostFlagZero = 1'b0;
    logic extRead, extReadDone, progWrite, runStart, hostReady, loaderBusy;
    logic [3:0] pin = 4'h0, operatingModeReg, extAttrStrobe;
    logic [23:0] hostData = 24'h0, extAddr, progAddr, progData, runAddr;
    logic [7:0] extReadData, eb;
    logic [17:0] extPinAddr;
    logic [4:0] extWaitStates;
    logic [1:0] extAccessType;
    logic [47:0] wq [$];
    logic [23:0] runs [$];
    logic [7:0] eq [$];
    int bad_count = 0, n_tests = 0;
    localparam logic [7:0] SB [9] = '{8'h01, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h33,
        8'h22, 8'h11};
    rmb_loader u_rmb_loader (.modePinA(pin[0]), .modePinB(pin[1]), .modePinC(pin[2]),
        .modePinD(pin[3]), .modeWriteData(pin), .*);
    rmb_boot_mem u_rmb_boot_mem (.*);
    initial forever #12.5 clk = ~clk;
    initial #7 forever #62.5 serClk = ~serClk;
    // Record program writes and run starts as they happen.
    always @(posedge clk)
    begin
        if (progWrite === 1'b1) wq.push_back({progAddr, progData});
        if (runStart === 1'b1) runs.push_back(runAddr);
    end
    // Receive the echoed bytes at mid-bit.
    initial forever
    begin
        @(negedge serTxd);
        repeat (8) @(posedge serClk);
        for (int k = 0; k < 8; k++)
        begin
            repeat (16) @(posedge serClk);
            eb[k] = serTxd;
        end
        eq.push_back(eb);
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        if (bad_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic limit(input int i);
        if (i >= 20000)
        begin
            bad_count++;
            give_verdict();
        end
    endtask
    task automatic boot(input logic [3:0] m);
        resetn = 1'b0;
        pin = m;
        repeat (8) @(posedge clk);
        #2 resetn = 1'b1;
        repeat (3) @(posedge clk) #2;
        chk(operatingModeReg, m);
        wq.delete();
        runs.delete();
        eq.delete();
    endtask
    task automatic wait_run(input logic [23:0] a);
        int i;
        for (i = 0; i < 20000 && runs.size() == 0; i++) @(posedge clk) #2;
        limit(i);
        chk(runs.pop_front(), a);
    endtask
    // Serial frame: start bit, eight data bits low first, one stop bit.
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int k = 0; k < 10; k++)
        begin
            @(posedge serClk) #2 serRxd = f[k];
            repeat (15) @(posedge serClk);
        end
    endtask
    task automatic hword(input logic [23:0] w);
        int i = 0;
        @(posedge clk) #2 hostData = w;
        hostValid = 1'b1;
        do @(posedge clk); while (hostReady !== 1'b1 && ++i < 20000);
        limit(i);
        #2 hostValid = 1'b0;
    endtask
    initial
    begin
        int i;
        boot(4'h1);
        for (i = 0; i < 20000 && extRead !== 1'b1; i++) @(posedge clk) #2;
        limit(i);
        chk(extAddr, 24'hd00000);
        chk({extAttrStrobe, extWaitStates}, {4'h2, 5'h1f});
        wait_run(24'h10);
        chk(wq.size(), 2);
        chk(wq[0], {24'h10, 24'h123456});
        chk(wq[1], {24'h11, 24'habcdef});
        boot(4'h0);
        wait_run(24'hc00000);
        chk({extPinAddr, extAccessType, extAttrStrobe}, 24'h0);
        boot(4'h3);
        repeat (4) @(posedge clk) #2;
        chk({loaderBusy, runs.size()}, 0);
        pin = 4'h1;
        modeWrite = 1'b1;
        @(posedge clk) #2 modeWrite = 1'b0;
        loaderJump = 1'b1;
        @(posedge clk) #2 loaderJump = 1'b0;
        wait_run(24'h10);
        boot(4'h2);
        for (i = 0; i < 9; i++) send(SB[i]);
        wait_run(24'h20);
        chk(wq[0], {24'h20, 24'h112233});
        repeat (1000) @(posedge clk);
        for (i = 0; i < 9; i++) chk(eq[i], SB[i]);
        boot(4'h4);
        progReady = 1'b0;
        hword(24'h5);
        hword(24'h30);
        hword(24'h0a0b0c);
        hostFlagZero = 1'b1;
        repeat (8) @(posedge clk) #2;
        chk(runs.size(), 0);
        progReady = 1'b1;
        wait_run(24'h30);
        chk(wq.size(), 1);
        chk(wq[0], {24'h30, 24'h0a0b0c});
        give_verdict();
    end
endmodule
`default_nettype wire
